/* File: verilog/ricfg_pkg.sv */
// Package of constants and carrier types for the reset, init and configuration store block
package ricfg_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ            = 40_000_000;
    localparam int unsigned EXIT_MAX_US       = 1000;   // Reset exit at most 1 ms
    localparam int unsigned INIT_MS           = 20;     // Initialization about 20 ms
    localparam int unsigned EXIT_CYCLES       = (CLK_HZ / 1_000_000) * EXIT_MAX_US;
    localparam int unsigned INIT_CYCLES       = (CLK_HZ / 1000) * INIT_MS;
    // Configuration store
    localparam int unsigned CFG_DEPTH         = 16;
    localparam int unsigned CFG_AW            = 4;
    localparam logic [7:0]  CMD_STORE_ALL     = 8'h11;
    localparam logic [7:0]  CMD_ROM_ENTRY     = 8'hd9;  // Boot-ROM entry code, arbitrary
    localparam logic [6:0]  ADDR_FALLBACK     = 7'h7e;  // Address 126
    localparam logic [7:0]  CFG_RESET_VALUE   = 8'h00;
    // Pin counts
    localparam int unsigned FAST_PWM_PINS_W            = 8;
    localparam int unsigned GPIO_W            = 16;
    localparam int unsigned TAP_PINS          = 6;
    localparam int unsigned TAP_GPIO_PINS     = 4;

    // Phases of the device
    typedef enum logic [1:0] {ST_RESET, ST_EXIT, ST_INIT, ST_RUN} ricfg_phase_type;

    // Host command from the bus front end
    typedef struct packed {
        logic       valid;
        logic       send_byte;   // Send-byte: command only
        logic [7:0] code;
        logic [7:0] data;
    } ricfg_cmd_type;

    // Flash write port
    typedef struct packed {
        logic                 we;
        logic [CFG_AW-1:0]    addr;
        logic [7:0]           data;
    } ricfg_flash_wr_type;
endpackage : ricfg_pkg

/* File: verilog/ricfg_top.sv */
// Reset exit, initialization, configuration store and test-port mux control
`timescale 1ns/100ps
module ricfg_top #(
    parameter int unsigned EXIT_CYCLES_P = ricfg_pkg::EXIT_CYCLES,
    parameter int unsigned INIT_CYCLES_P = ricfg_pkg::INIT_CYCLES
) (
    // Clock and reset
    input  wire logic                               clk_sys_in,
    input  wire logic                               reset_in,
    // Reset sources (asynchronous pins)
    input  wire logic                               supply_good_in,
    input  wire logic                               ext_reset_in_n,
    // Address detect results
    input  wire logic [6:0]                         bus_addr_in,
    input  wire logic                               addr_pin_bad_in,
    // Host commands and configuration writes
    input  wire ricfg_pkg::ricfg_cmd_type           cmd_in,
    // Flash content and state
    input  wire logic [7:0]                         flash_rd_data_in,
    input  wire logic                               flash_blank_in,
    // Run-time pin values from the sequencer core
    input  wire logic [ricfg_pkg::FAST_PWM_PINS_W-1:0]       fast_pwm_pins_val_in,
    input  wire logic [ricfg_pkg::GPIO_W-1:0]       gpio_val_in,
    input  wire logic [ricfg_pkg::GPIO_W-1:0]       gpio_en_in,
    // Pins and status
    output logic [ricfg_pkg::FAST_PWM_PINS_W-1:0]            fast_pwm_pins_out,
    output logic [ricfg_pkg::GPIO_W-1:0]            gpio_pins_out,
    output logic [ricfg_pkg::GPIO_W-1:0]            gpio_pins_oe_out,
    output logic                                    tap_enable_out,
    output logic                                    seq_enable_out,
    output logic                                    in_reset_out,
    output logic                                    init_done_out,
    output logic [6:0]                              bus_addr_out,
    output logic                                    store_busy_out,
    output ricfg_pkg::ricfg_flash_wr_type           flash_wr_out,
    output logic [ricfg_pkg::CFG_AW-1:0]            flash_rd_addr_out
);

    localparam int unsigned CW = 32;

    // Two-stage synchronisers for the asynchronous pins
    logic supply_s1_reg, supply_s2_reg, nrst_s1_reg, nrst_s2_reg;
    always_ff @(posedge clk_sys_in) begin
        supply_s1_reg <= supply_good_in;
        supply_s2_reg <= supply_s1_reg;
        nrst_s1_reg   <= ext_reset_in_n;
        nrst_s2_reg   <= nrst_s1_reg;
    end

    ricfg_pkg::ricfg_phase_type phase_reg;
    logic [CW-1:0] cnt_reg;
    logic          held_reset;
    logic          boot_reg;        // First reset exit since power-up
    logic          load_done_reg;
    logic [ricfg_pkg::CFG_AW:0] load_idx_reg;
    logic [7:0]    cfg_ram [ricfg_pkg::CFG_DEPTH];
    logic          programmed_reg;
    logic [ricfg_pkg::CFG_AW:0] st_idx_reg;

    assign held_reset = reset_in | ~supply_s2_reg | ~nrst_s2_reg;

    // Phase sequencing: reset, exit delay, initialization, run
    always_ff @(posedge clk_sys_in) begin
        if (held_reset) begin
            phase_reg <= ricfg_pkg::ST_RESET;
            cnt_reg   <= '0;
        end else begin
            case (phase_reg)
                ricfg_pkg::ST_RESET: begin
                    phase_reg <= ricfg_pkg::ST_EXIT;
                    cnt_reg   <= '0;
                end
                ricfg_pkg::ST_EXIT: begin
                    if (cnt_reg >= CW'(EXIT_CYCLES_P - 4)) begin // Sync, entry and status flops add four
                        phase_reg <= ricfg_pkg::ST_INIT;
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                ricfg_pkg::ST_INIT: begin
                    if (cnt_reg >= CW'(INIT_CYCLES_P - 1) && load_done_reg) begin
                        phase_reg <= ricfg_pkg::ST_RUN;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                default: phase_reg <= ricfg_pkg::ST_RUN;
            endcase
        end
    end

    // Power-up marker: set only by supply loss or system reset, cleared once the run phase is reached
    always_ff @(posedge clk_sys_in) begin
        if (reset_in | ~supply_s2_reg) begin
            boot_reg <= 1'b1;
        end else if (phase_reg == ricfg_pkg::ST_RUN) begin
            boot_reg <= 1'b0;
        end
    end

    // Flash to RAM load during initialization, one word per cycle
    always_ff @(posedge clk_sys_in) begin
        if (held_reset) begin
            load_idx_reg  <= '0;
            load_done_reg <= 1'b0;
        end else if (phase_reg == ricfg_pkg::ST_INIT && !load_done_reg) begin
            load_idx_reg <= load_idx_reg + 1'b1;
            if (load_idx_reg == (ricfg_pkg::CFG_AW+1)'(ricfg_pkg::CFG_DEPTH)) begin
                load_done_reg <= 1'b1;
            end
        end
    end

    // Store sequence index; CFG_DEPTH means idle
    logic store_start;
    assign store_start = cmd_in.valid && cmd_in.send_byte && cmd_in.code == ricfg_pkg::CMD_STORE_ALL
                         && phase_reg == ricfg_pkg::ST_RUN;

    logic rom_cmd;
    assign rom_cmd = cmd_in.valid && cmd_in.send_byte && cmd_in.code == ricfg_pkg::CMD_ROM_ENTRY
                     && phase_reg == ricfg_pkg::ST_RUN;

    // Configuration RAM: load from flash, host writes
    always_ff @(posedge clk_sys_in) begin
        // Flash read data belongs to the current index
        if (phase_reg == ricfg_pkg::ST_INIT && !load_done_reg && !load_idx_reg[ricfg_pkg::CFG_AW]) begin
            cfg_ram[load_idx_reg[ricfg_pkg::CFG_AW-1:0]] <= flash_rd_data_in;
        end else if (cmd_in.valid && !cmd_in.send_byte && phase_reg == ricfg_pkg::ST_RUN
                     && cmd_in.code[7:ricfg_pkg::CFG_AW] == '0) begin
            cfg_ram[cmd_in.code[ricfg_pkg::CFG_AW-1:0]] <= cmd_in.data;
        end
    end
    assign flash_rd_addr_out = load_idx_reg[ricfg_pkg::CFG_AW-1:0];

    always_ff @(posedge clk_sys_in) begin
        if (held_reset) begin
            st_idx_reg     <= (ricfg_pkg::CFG_AW+1)'(ricfg_pkg::CFG_DEPTH);
            flash_wr_out   <= '0;
            store_busy_out <= 1'b0;
        end else if (store_start && st_idx_reg[ricfg_pkg::CFG_AW]) begin
            st_idx_reg     <= '0;
            store_busy_out <= 1'b1;
            flash_wr_out   <= '0;
        end else if (!st_idx_reg[ricfg_pkg::CFG_AW]) begin
            flash_wr_out.we   <= 1'b1;
            flash_wr_out.addr <= st_idx_reg[ricfg_pkg::CFG_AW-1:0];
            flash_wr_out.data <= cfg_ram[st_idx_reg[ricfg_pkg::CFG_AW-1:0]];
            st_idx_reg        <= st_idx_reg + 1'b1;
        end else begin
            flash_wr_out   <= '0;
            store_busy_out <= 1'b0;
        end
    end

    // Programmed flag is sampled from flash state at end of init
    always_ff @(posedge clk_sys_in) begin
        if (held_reset) begin
            programmed_reg <= 1'b0;
        end else if (phase_reg == ricfg_pkg::ST_INIT && load_done_reg) begin
            programmed_reg <= ~flash_blank_in;
        end
    end

    // Test-port enable
    always_ff @(posedge clk_sys_in) begin
        if (held_reset) begin
            tap_enable_out <= 1'b0;
        end else if (phase_reg == ricfg_pkg::ST_INIT && boot_reg && (flash_blank_in || addr_pin_bad_in)) begin
            tap_enable_out <= 1'b1;
        end else if (rom_cmd) begin
            tap_enable_out <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (held_reset) begin
            bus_addr_out <= ricfg_pkg::ADDR_FALLBACK;
        end else if (phase_reg == ricfg_pkg::ST_INIT) begin
            bus_addr_out <= addr_pin_bad_in ? ricfg_pkg::ADDR_FALLBACK : bus_addr_in;
        end
    end

    // Pin drive by phase
    always_ff @(posedge clk_sys_in) begin
        if (held_reset || phase_reg != ricfg_pkg::ST_RUN) begin
            fast_pwm_pins_out <= '0;
            gpio_pins_out     <= '0;
            gpio_pins_oe_out  <= '0;
            seq_enable_out    <= 1'b0;
        end else begin
            fast_pwm_pins_out <= programmed_reg ? fast_pwm_pins_val_in : '0;
            gpio_pins_out     <= gpio_val_in;
            gpio_pins_oe_out  <= programmed_reg ? gpio_en_in : '0;
            seq_enable_out    <= programmed_reg;
            // Port used for programming
            // Lanes let go in the cycle the port turns on
            if (tap_enable_out || rom_cmd) begin
                gpio_pins_oe_out[ricfg_pkg::TAP_GPIO_PINS-1:0] <= '0;
            end
        end
    end

    // Status flags
    always_ff @(posedge clk_sys_in) begin
        in_reset_out  <= held_reset || phase_reg == ricfg_pkg::ST_RESET || phase_reg == ricfg_pkg::ST_EXIT;
        init_done_out <= !held_reset && phase_reg == ricfg_pkg::ST_RUN;
    end

endmodule : ricfg_top

/* File: testbench/ricfg_asserts.sv */
// Port checker for the reset, init and configuration store block
`timescale 1ns/100ps
module ricfg_asserts #(
    parameter int unsigned EXIT_CYCLES_P = 4
) (
    // Clock and reset
    input wire logic                          clk_sys_in,
    input wire logic                          reset_in,
    // Watched inputs
    input wire logic                          supply_good_in,
    input wire logic                          ext_reset_in_n,
    input wire ricfg_pkg::ricfg_cmd_type      cmd_in,
    // Watched outputs
    input wire logic [ricfg_pkg::FAST_PWM_PINS_W-1:0]  fast_pwm_pins_out,
    input wire logic [ricfg_pkg::GPIO_W-1:0]  gpio_pins_oe_out,
    input wire logic                          tap_enable_out,
    input wire logic                          seq_enable_out,
    input wire logic                          in_reset_out,
    input wire logic                          init_done_out,
    input wire logic [6:0]                    bus_addr_out,
    input wire logic                          store_busy_out,
    input wire ricfg_pkg::ricfg_flash_wr_type flash_wr_out
);
    localparam int EXB = EXIT_CYCLES_P + 4;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    // Accepted host commands
    wire run_cmd = cmd_in.valid && cmd_in.send_byte && init_done_out;
    wire store = run_cmd && cmd_in.code == ricfg_pkg::CMD_STORE_ALL;
    property p_rst_safe;
        disable iff (1'h0) reset_in |=> !tap_enable_out && bus_addr_out == 7'h7e && gpio_pins_oe_out == '0;
    endproperty
    a_rst_safe: assert property (p_rst_safe) else $error("unsafe pins in reset");
    property p_in_reset;
        disable iff (1'h0) !supply_good_in [*3] |-> ##[0:2] in_reset_out;
    endproperty
    a_in_reset: assert property (p_in_reset) else $error("supply low without reset");
    property p_exit;
        $rose(ext_reset_in_n) && supply_good_in |-> ##[1:EXB] !in_reset_out;
    endproperty
    a_exit: assert property (p_exit) else $error("reset exit too slow");
    property p_init_quiet;
        !init_done_out |-> fast_pwm_pins_out == '0 && gpio_pins_oe_out == '0;
    endproperty
    a_init_quiet: assert property (p_init_quiet) else $error("pins driven during init");
    property p_unprog;
        gpio_pins_oe_out != '0 |-> seq_enable_out;
    endproperty
    a_unprog: assert property (p_unprog) else $error("pins driven while unprogrammed");
    property p_tap_gpio;
        tap_enable_out |-> gpio_pins_oe_out[3:0] == 4'h0;
    endproperty
    a_tap_gpio: assert property (p_tap_gpio) else $error("shared lanes driven with port on");
    property p_store;
        store && !store_busy_out |=> store_busy_out ##1 flash_wr_out.we && flash_wr_out.addr == 4'h0;
    endproperty
    a_store: assert property (p_store) else $error("store copy did not start");
    property p_wr_seq;
        flash_wr_out.we && flash_wr_out.addr != 4'hf |=> flash_wr_out.we && flash_wr_out.addr == $past(flash_wr_out.addr) + 4'h1;
    endproperty
    a_wr_seq: assert property (p_wr_seq) else $error("copy word order broken");
    property p_wr_end;
        flash_wr_out.we && flash_wr_out.addr == 4'hf |=> !flash_wr_out.we ##1 !store_busy_out;
    endproperty
    a_wr_end: assert property (p_wr_end) else $error("copy did not finish");
    property p_rom;
        run_cmd && cmd_in.code == ricfg_pkg::CMD_ROM_ENTRY |=> tap_enable_out;
    endproperty
    a_rom: assert property (p_rom) else $error("boot entry left port off");
    c_store: cover property (store);
    c_rom: cover property (tap_enable_out && init_done_out);
    c_run: cover property (seq_enable_out);
endmodule : ricfg_asserts
bind ricfg_top ricfg_asserts #(.EXIT_CYCLES_P(EXIT_CYCLES_P)) u_ricfg_asserts (.*);

/* File: testbench/ricfg_host_model.sv */
// Host controller and external reset circuit model
`timescale 1ns/100ps
module ricfg_host_model #(
    parameter int STORE_WAIT = 40
) (
    // Clock
    input  wire logic               clk_sys_in,
    // Toward the device
    output ricfg_pkg::ricfg_cmd_type cmd_out,
    output logic                    ext_reset_out_n
);
    initial begin
        cmd_out = '0;
        ext_reset_out_n = 1'h1;
    end
    task automatic send(input logic sb, input logic [7:0] code, input logic [7:0] data);
        @(posedge clk_sys_in);
        #2 cmd_out = '{1'h1, sb, code, data};
        @(posedge clk_sys_in);
        #2 cmd_out = '{1'h0, ~sb, ~code, ~data}; // Idle lines carry junk
        if (sb && code == ricfg_pkg::CMD_STORE_ALL) repeat (STORE_WAIT) @(posedge clk_sys_in);
    endtask : send
    task automatic pulse_reset(input int n);
        @(posedge clk_sys_in);
        #2 ext_reset_out_n = 1'h0;
        repeat (n) @(posedge clk_sys_in);
        #2 ext_reset_out_n = 1'h1;
    endtask : pulse_reset
endmodule : ricfg_host_model

/* File: testbench/tb.sv */
// Self-checking bench for the reset, init and configuration store block
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
    $display("unexpected %s: expected %h seen %h", n, e, a); end end
module tb;
    localparam int EX = 4;
    localparam int IN = 40;
    int                            mismatches = 0;
    int                            n_tests = 0;
    int                            wr_idx = 0;
    int                            ram [16];
    logic                          clk_sys_in = 1'h0;
    logic                          reset_in = 1'h1;
    logic                          supply_good_in = 1'h1;
    logic                          addr_pin_bad_in = 1'h0;
    logic                          flash_blank_in = 1'h0;
    logic [6:0]                    bus_addr_in = 7'h21;
    logic [7:0]                    fast_pwm_pins_val_in = '0;
    logic [15:0]                   gpio_val_in = '0;
    logic [15:0]                   gpio_en_in = '0;
    logic                          ext_reset_in_n;
    ricfg_pkg::ricfg_cmd_type      cmd_in;
    logic [7:0]                    fast_pwm_pins_out;
    logic [15:0]                   gpio_pins_out, gpio_pins_oe_out;
    logic                          tap_enable_out, seq_enable_out, in_reset_out, init_done_out, store_busy_out;
    logic [6:0]                    bus_addr_out;
    logic [3:0]                    flash_rd_addr_out;
    ricfg_pkg::ricfg_flash_wr_type flash_wr_out;
    wire  [7:0]                    flash_rd_data_in = {4'h3, flash_rd_addr_out};
    // Device and host
    ricfg_top #(.EXIT_CYCLES_P(EX), .INIT_CYCLES_P(IN)) u_ricfg_top (.*);
    ricfg_host_model #(.STORE_WAIT(2)) u_ricfg_host_model (
        .clk_sys_in      (clk_sys_in),
        .cmd_out         (cmd_in),
        .ext_reset_out_n (ext_reset_in_n)
    );
    always #12.5 clk_sys_in = ~clk_sys_in;
    // Flash copy against the RAM model
    always @(negedge clk_sys_in) if (flash_wr_out.we === 1'h1) begin
        `CHK("wr_addr", wr_idx[3:0], flash_wr_out.addr)
        `CHK("wr_data", ram[wr_idx][7:0], flash_wr_out.data)
        wr_idx++;
    end
    task automatic wait_run;
        int n;
        n = 0;
        foreach (ram[i]) ram[i] = 8'h30 + i;
        while (init_done_out !== 1'h1 && n < 500) begin
            @(posedge clk_sys_in);
            #2 n++;
            if (init_done_out !== 1'h1) `CHK("pwm_init", 8'h00, fast_pwm_pins_out)
        end
        `CHK("init_len", 1'h1, n >= IN && n < 500)
    endtask : wait_run
    task automatic power_up(input logic blank, input logic bad, input logic sup);
        @(posedge clk_sys_in);
        #2 flash_blank_in = blank;
        addr_pin_bad_in = bad;
        if (sup) supply_good_in = 1'h0;
        else reset_in = 1'h1;
        repeat (sup ? 4 : 1) @(posedge clk_sys_in);
        #2 `CHK("in_reset", 1'h1, in_reset_out)
        `CHK("addr_rst", 7'h7e, bus_addr_out)
        reset_in = 1'h0;
        supply_good_in = 1'h1;
        wait_run();
    endtask : power_up
    task automatic check_run(input logic tap);
        `CHK("tap", tap, tap_enable_out)
        `CHK("seq", ~flash_blank_in, seq_enable_out)
        `CHK("pwm", flash_blank_in ? 8'h00 : fast_pwm_pins_val_in, fast_pwm_pins_out)
        `CHK("oe", flash_blank_in ? 16'h0 : gpio_en_in & {12'hfff, {4{~tap}}}, gpio_pins_oe_out)
        `CHK("addr", addr_pin_bad_in ? 7'h7e : bus_addr_in, bus_addr_out)
        `CHK("gpio", gpio_val_in, gpio_pins_out)
    endtask : check_run
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        int n;
        logic [7:0] c, d;
        n = $urandom(32'h6a87);
        // Random pin values before the first edge
        fast_pwm_pins_val_in = $urandom;
        gpio_en_in = $urandom;
        gpio_val_in = $urandom;
        power_up(1'h1, 1'h0, 1'h0);
        check_run(1'h1);
        power_up(1'h0, 1'h1, 1'h1);
        check_run(1'h1);
        power_up(1'h0, 1'h0, 1'h0);
        check_run(1'h0);
        // Parameter writes, some out of range
        repeat (20) begin
            c = $urandom_range(19);
            d = $urandom;
            u_ricfg_host_model.send(1'h0, c, d);
            if (c < 16) ram[c] = d;
        end
        `CHK("wr_early", 0, wr_idx)
        u_ricfg_host_model.send(1'h1, ricfg_pkg::CMD_STORE_ALL, 8'h00);
        u_ricfg_host_model.send(1'h1, ricfg_pkg::CMD_STORE_ALL, 8'h00);
        repeat (24) @(posedge clk_sys_in);
        `CHK("wr_count", 16, wr_idx)
        u_ricfg_host_model.send(1'h1, ricfg_pkg::CMD_ROM_ENTRY, 8'h00);
        `CHK("tap_rom", 1'h1, tap_enable_out)
        repeat (20) @(posedge clk_sys_in);
        check_run(1'h1);
        u_ricfg_host_model.pulse_reset(6);
        n = 0;
        while (in_reset_out !== 1'h0 && n < 100) begin
            @(posedge clk_sys_in);
            #2 n++;
        end
        `CHK("exit_len", 1'h1, n <= EX + 1)
        wait_run();
        check_run(1'h0);
        tally_and_finish();
    end
    // Hang guard
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        mismatches++;
        tally_and_finish();
    end
endmodule : tb
